// ===== common/lbd_pkg.sv
// Constants, register map and types of the line blockage diagnosis bank.
// Assumes a 10 MHz clock and a 12-bit word address from the host port.
package lbd_pkg;

  // Clock and timing
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          SEC_PER_TICK    = 1;
  localparam int          CYCLES_PER_SEC  = CLK_HZ * SEC_PER_TICK;
  localparam int          REF_TIME_S      = 180;
  localparam logic [7:0]  REF_TIME_CNT    = 8'(REF_TIME_S);

  // Widths
  localparam int          AW              = 12;
  localparam int          DW              = 16;

  // Register offsets
  localparam logic [11:0] OFF_MODE        = 12'h812;
  localparam logic [11:0] OFF_PERIOD      = 12'h813;
  localparam logic [11:0] OFF_PRI         = 12'h814;
  localparam logic [11:0] OFF_RESULT      = 12'h815;
  localparam logic [11:0] OFF_HALERT      = 12'h816;
  localparam logic [11:0] OFF_LALERT      = 12'h817;
  localparam logic [11:0] OFF_MASK        = 12'h818;
  localparam logic [11:0] OFF_BLKMODE     = 12'h819;
  localparam logic [11:0] OFF_COMP        = 12'h81A;
  localparam logic [11:0] OFF_COUNT       = 12'h81B;
  localparam logic [11:0] OFF_RTIME_LO    = 12'h81C;
  localparam logic [11:0] OFF_RTIME_HI    = 12'h81D;
  localparam logic [11:0] OFF_LIM_BASE    = 12'h81E;
  localparam int          NUM_LIM         = 10;

  // Reset values and ranges
  localparam logic [15:0] PERIOD_RST      = 16'h00B4;
  localparam logic [15:0] PERIOD_MIN      = 16'h0014;
  localparam logic [7:0]  PRI_RST         = 8'h01;
  localparam logic [15:0] RESULT_RST      = 16'h0000;
  localparam logic [15:0] MASK_RST        = 16'h08FC;
  localparam logic [7:0]  COUNT_RST       = 8'h03;
  localparam logic [15:0] LIM_MAX_RST     = 16'h0200;
  localparam logic [15:0] LIM_MIN_RST     = 16'h0080;
  localparam logic [15:0] LIM_HI_RST      = 16'h7FFF;
  localparam logic [15:0] LIM_LO_RST      = 16'h0000;

  // Result bit positions
  localparam int          B_A_BLK         = 2;
  localparam int          B_LFL_LO        = 3;
  localparam int          B_LFL_HI        = 4;
  localparam int          B_LO_BLK        = 5;
  localparam int          B_HI_BLK        = 6;
  localparam int          B_B_BLK         = 7;
  localparam int          B_INV_BLOCKING_FACTOR      = 8;
  localparam int          B_INV_HIGH_SIDE_FLUCT      = 9;
  localparam int          B_INV_LOW_SIDE_FLUCT      = 10;
  localparam int          B_INV_FDP       = 11;
  localparam int          B_RANGE         = 12;
  localparam int          B_FT_LO         = 13;
  localparam int          B_FT_HI         = 14;
  localparam int          B_LINK_STATUS   = 15;
  localparam logic [15:0] H_ALERT_BITS    = 16'h1BD4;
  localparam logic [15:0] L_ALERT_BITS    = 16'h1DAC;

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_CALC = 2'b01,
    MODE_REF  = 2'b10
  } diag_mode_e;

  typedef enum logic [1:0] {
    BM_OOS  = 2'b00,
    BM_MAN  = 2'b01,
    BM_AUTO = 2'b10
  } blk_mode_e;

endpackage : lbd_pkg

// ===== rtl/line_blockage_diag_params.sv
// Parameter and status bank of the impulse line blockage diagnosis.
// Assumes statistics and flange temperature flags come from logic on CLK.
//
// How it works
// RL1: Mode selector: stop 0, calculation 1, reference 2; resets to stop.
// RL2: Evaluation only in calculation; result and alarms held in reference, cleared when stopped.
// RL3: Reference mode captures new baselines, then switches itself to calculation.
// RL4: Acquisition period accepts 20..65535 seconds, default 180; host stays in range.
// RL5: Period, priority and mask writable only while stopped; host stops first.
// RL6: One priority for both high and low alerts, default 1.
// RL7: Result bits 2..7 flag blocking and large fluctuation outcomes.
// RL8: Result bits 8..11 flag invalid baseline values.
// RL9: Bits 12..14 flag range and flange temperature; result resets to zero.
// RL10: High alert from A, B, high fluct, high block, invalid refs, range.
// RL11: Low alert from A, B, low fluct, low block, invalid refs, range.
// RL12: Mask bit selects result bit for analog alert and display; default 0x08FC.
// RL13: Mask bit 15 plus abnormality marks three output values uncertain.
// RL14: Compensated ratio: sqrt of statistic over baseline times mean pressure ratio.
// RL15: Uncompensated ratio: plain sqrt of statistic over baseline.
// RL16: Host re-acquires reference when flow moves 25 percent or more.
// RL17: Write classes follow block mode: out of service, manual, auto; every write here uses the auto class, allowed in all block modes.
// RL18: Blockage declared after a preset count of consecutive crossings, default 3.
// RL19: Reference ends after 180 seconds; mode to calculation, time recorded.
// RL20: Ten thresholds decide the result bits from ratios and mean pressure.
// RL21: Bits 0 and 1 read zero; result bits follow the latest evaluation.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module line_blockage_diag_params #(
  parameter int CYCLES_PER_SEC = lbd_pkg::CYCLES_PER_SEC
) (
  // Clock and reset
  input  wire logic                   CLK,
  input  wire logic                   NRST,
  // Register port
  input  wire logic [lbd_pkg::AW-1:0] ADDR,
  input  wire logic [lbd_pkg::DW-1:0] WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [lbd_pkg::DW-1:0] RDATA,
  // Statistics engine
  input  wire logic [15:0]            STAT_FDP,
  input  wire logic [15:0]            STAT_LOW_SIDE_FLUCT,
  input  wire logic [15:0]            STAT_HIGH_SIDE_FLUCT,
  input  wire logic [15:0]            STAT_BLOCKING_FACTOR,
  input  wire logic [15:0]            STAT_DPAVG,
  input  wire logic                   FLANGE_TEMP_LOW,
  input  wire logic                   FLANGE_TEMP_HIGH,
  // Alarms and status
  output logic [1:0]                  MODE_STATE,
  output logic [7:0]                  ALERT_PRIORITY,
  output logic                        HIGH_ALERT,
  output logic                        LOW_ALERT,
  output logic [14:0]                 LINKED_ALARMS,
  output logic                        ANALOG_ALERT,
  output logic                        OUTPUT_UNCERTAIN
);
  import lbd_pkg::*;

  typedef struct packed {
    diag_mode_e        mode;
    blk_mode_e         blk_mode;
    logic [15:0]       period;
    logic [7:0]        pri;
    logic [15:0]       mask;
    logic              comp_off;
    logic [7:0]        count_lim;
    logic [9:0][15:0]  lim;
    logic [15:0]       base_fdp;
    logic [15:0]       base_low_side_fluct;
    logic [15:0]       base_high_side_fluct;
    logic [15:0]       base_blocking_factor;
    logic [15:0]       base_dpavg;
    logic [5:0][7:0]   hits;
    logic [15:0]       result;
    logic [31:0]       now_s;
    logic [31:0]       ref_time;
    logic [31:0]       pre;
    logic [15:0]       per_s;
    logic [7:0]        ref_s;
    logic [15:0]       rdata;
    logic              h_alert;
    logic              l_alert;
    logic [14:0]       linked;
    logic              analog;
    logic              uncertain;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // Integer square root, 32 bit in, 16 bit out
  function automatic logic [15:0] isqrt(input logic [31:0] x);
    logic [15:0] r;
    logic [15:0] c;
    r = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      c = r | (16'h0001 << i);
      if ({16'h0000, c} * {16'h0000, c} <= x) begin
        r = c;
      end
    end
    return r;
  endfunction : isqrt

  // Fluctuation ratio in 8.8 fixed point
  function automatic logic [15:0] fl_ratio(input logic [15:0] v, input logic [15:0] b);
    logic [31:0] q;
    q = 32'h0000_0000;
    if (b == 16'h0000) begin
      return 16'hFFFF;
    end
    q = {v, 16'h0000} / {16'h0000, b};
    return isqrt(q);
  endfunction : fl_ratio

  // Magnitude of a signed pressure
  function automatic logic [15:0] mag(input logic [15:0] p);
    return p[15] ? 16'(-p) : p;
  endfunction : mag

  // Write permission by parameter class and block mode
  function automatic logic wr_ok(input blk_mode_e cls, input blk_mode_e bm);
    case (cls)
      BM_OOS:  return bm == BM_OOS;
      BM_MAN:  return (bm == BM_OOS) || (bm == BM_MAN);
      default: return 1'b1;
    endcase
  endfunction : wr_ok

  // Consecutive hit counter step
  function automatic logic [7:0] hit_step(input logic hit, input logic [7:0] n);
    if (!hit) begin
      return 8'h00;
    end
    return (n == 8'hFF) ? n : n + 8'h01;
  endfunction : hit_step

  // Threshold word decode
  function automatic logic lim_sel(input logic [lbd_pkg::AW-1:0] a, input int k);
    return a == OFF_LIM_BASE + 12'(k);
  endfunction : lim_sel

  logic [15:0] r_fdp;
  logic [15:0] r_cfdp;
  logic [15:0] r_low_side_fluct;
  logic [15:0] r_high_side_fluct;
  logic [31:0] comp_prod;
  logic [31:0] comp_q;
  logic [5:0]  hit;
  logic [5:0]  hit_ok;
  logic [15:0] eval;
  logic        inv_fdp;
  logic        inv_low_side_fluct;
  logic        inv_high_side_fluct;
  logic        inv_blocking_factor;
  logic        tick;
  logic        stopped;
  logic        perm;

  always_comb begin
    r_fdp     = fl_ratio(STAT_FDP, s_r.base_fdp);                   // [RL15]
    comp_prod = {16'h0000, r_fdp} * {16'h0000, mag(s_r.base_dpavg)};
    comp_q    = (mag(STAT_DPAVG) == 16'h0000) ? 32'hFFFF_FFFF
              : comp_prod / {16'h0000, mag(STAT_DPAVG)};
    r_cfdp    = (comp_q[31:16] != 16'h0000) ? 16'hFFFF : comp_q[15:0]; // [RL14]
    if (s_r.comp_off) begin
      r_cfdp = r_fdp;                                                // [RL15]
    end
    r_low_side_fluct   = fl_ratio(STAT_LOW_SIDE_FLUCT, s_r.base_low_side_fluct);
    r_high_side_fluct   = fl_ratio(STAT_HIGH_SIDE_FLUCT, s_r.base_high_side_fluct);
    inv_fdp  = s_r.base_fdp  == 16'h0000;                            // [RL8]
    inv_low_side_fluct = s_r.base_low_side_fluct == 16'h0000;                            // [RL8]
    inv_high_side_fluct = s_r.base_high_side_fluct == 16'h0000;                            // [RL8]
    inv_blocking_factor = s_r.base_blocking_factor == 16'h0000;                            // [RL8]
    // Index 0..5 follows result bits 2..7 [RL20]
    hit[0] = !inv_fdp  && (r_cfdp > s_r.lim[0]);
    hit[1] = !inv_low_side_fluct && (r_low_side_fluct > s_r.lim[2]);
    hit[2] = !inv_high_side_fluct && (r_high_side_fluct > s_r.lim[4]);
    hit[3] = (!inv_low_side_fluct && (r_low_side_fluct < s_r.lim[3]))
           || (!inv_blocking_factor && (STAT_BLOCKING_FACTOR < s_r.lim[7]));
    hit[4] = (!inv_high_side_fluct && (r_high_side_fluct < s_r.lim[5]))
           || (!inv_blocking_factor && (STAT_BLOCKING_FACTOR > s_r.lim[6]));
    hit[5] = !inv_fdp  && (r_cfdp < s_r.lim[1]);
    for (int k = 0; k < 6; k++) begin
      hit_ok[k] = hit_step(hit[k], s_r.hits[k]) >= s_r.count_lim;   // [RL18]
    end
    eval = RESULT_RST;                                               // [RL21]
    eval[B_LO_BLK:B_A_BLK] = {hit_ok[3], hit_ok[2], hit_ok[1], hit_ok[0]}; // [RL7]
    eval[B_HI_BLK] = hit_ok[4];                                      // [RL7]
    eval[B_B_BLK]  = hit_ok[5];                                      // [RL7]
    eval[B_INV_BLOCKING_FACTOR] = inv_blocking_factor;                                     // [RL8]
    eval[B_INV_HIGH_SIDE_FLUCT] = inv_high_side_fluct;                                     // [RL8]
    eval[B_INV_LOW_SIDE_FLUCT] = inv_low_side_fluct;                                     // [RL8]
    eval[B_INV_FDP]  = inv_fdp;                                      // [RL8]
    eval[B_RANGE] = ($signed(STAT_DPAVG) < $signed(s_r.lim[9]))
                 || ($signed(STAT_DPAVG) > $signed(s_r.lim[8]));    // [RL9]
    eval[B_FT_LO] = FLANGE_TEMP_LOW;                                 // [RL9]
    eval[B_FT_HI] = FLANGE_TEMP_HIGH;                                // [RL9]
  end

  always_comb begin
    s_nxt   = s_r;
    tick    = s_r.pre == 32'(CYCLES_PER_SEC - 1);
    stopped = s_r.mode == MODE_STOP;
    perm    = wr_ok(BM_AUTO, s_r.blk_mode);                          // [RL17]
    s_nxt.pre   = tick ? 32'h0000_0000 : s_r.pre + 32'h0000_0001;
    s_nxt.now_s = tick ? s_r.now_s + 32'h0000_0001 : s_r.now_s;

    // Mode sequencing
    case (s_r.mode)
      MODE_STOP: begin
        s_nxt.hits   = '0;                                           // [RL2]
        s_nxt.result = RESULT_RST;
        s_nxt.per_s  = 16'h0000;
      end
      MODE_CALC: begin
        if (tick) begin
          s_nxt.per_s = s_r.per_s + 16'h0001;
          if (s_r.per_s + 16'h0001 >= s_r.period) begin
            s_nxt.per_s  = 16'h0000;
            s_nxt.result = eval;                                     // [RL2] [RL21]
            for (int k = 0; k < 6; k++) begin
              s_nxt.hits[k] = hit_step(hit[k], s_r.hits[k]);         // [RL18]
            end
          end
        end
      end
      MODE_REF: begin
        s_nxt.hits = '0;
        if (tick) begin
          s_nxt.ref_s = s_r.ref_s + 8'h01;
          if (s_r.ref_s + 8'h01 >= REF_TIME_CNT) begin               // [RL19]
            s_nxt.base_fdp   = STAT_FDP;                             // [RL3]
            s_nxt.base_low_side_fluct  = STAT_LOW_SIDE_FLUCT;
            s_nxt.base_high_side_fluct  = STAT_HIGH_SIDE_FLUCT;
            s_nxt.base_blocking_factor  = STAT_BLOCKING_FACTOR;
            s_nxt.base_dpavg = STAT_DPAVG;
            s_nxt.ref_time   = s_r.now_s;                            // [RL19]
            s_nxt.mode       = MODE_CALC;                            // [RL3]
            s_nxt.per_s      = 16'h0000;
            s_nxt.ref_s      = 8'h00;
          end
        end
      end
      default: begin
        s_nxt.mode = MODE_STOP;
      end
    endcase

    // Register writes
    if (WR) begin
      case (ADDR)
        OFF_MODE: begin
          if (perm && (WDATA <= 16'(MODE_REF))) begin                // [RL1]
            s_nxt.mode  = diag_mode_e'(WDATA[1:0]);
            s_nxt.ref_s = 8'h00;
            s_nxt.per_s = 16'h0000;
          end
        end
        OFF_PERIOD: begin
          if (perm && stopped && (WDATA >= PERIOD_MIN)) begin        // [RL4] [RL5]
            s_nxt.period = WDATA;
          end
        end
        OFF_PRI: begin
          if (perm && stopped) begin                                 // [RL5] [RL6]
            s_nxt.pri = WDATA[7:0];
          end
        end
        OFF_MASK: begin
          if (perm && stopped) begin                                 // [RL5] [RL12]
            s_nxt.mask = WDATA;
          end
        end
        OFF_BLKMODE: begin
          if (WDATA <= 16'(BM_AUTO)) begin                           // [RL17]
            s_nxt.blk_mode = blk_mode_e'(WDATA[1:0]);
          end
        end
        OFF_COMP: begin
          if (perm) begin
            s_nxt.comp_off = WDATA[0];                               // [RL14] [RL15]
          end
        end
        OFF_COUNT: begin
          if (perm && stopped && (WDATA[7:0] != 8'h00)) begin        // [RL18]
            s_nxt.count_lim = WDATA[7:0];
          end
        end
        default: begin
          for (int k = 0; k < NUM_LIM; k++) begin
            if (perm && stopped && lim_sel(ADDR, k)) begin          // [RL20]
              s_nxt.lim[k] = WDATA;
            end
          end
        end
      endcase
    end

    // Read data, one cycle after the strobe
    s_nxt.rdata = 16'h0000;
    if (RD) begin
      case (ADDR)
        OFF_MODE:     s_nxt.rdata = {14'h0000, s_r.mode};
        OFF_PERIOD:   s_nxt.rdata = s_r.period;
        OFF_PRI:      s_nxt.rdata = {8'h00, s_r.pri};
        OFF_RESULT:   s_nxt.rdata = s_r.result;                      // [RL21]
        OFF_HALERT:   s_nxt.rdata = s_r.result & H_ALERT_BITS;       // [RL10]
        OFF_LALERT:   s_nxt.rdata = s_r.result & L_ALERT_BITS;       // [RL11]
        OFF_MASK:     s_nxt.rdata = s_r.mask;
        OFF_BLKMODE:  s_nxt.rdata = {14'h0000, s_r.blk_mode};
        OFF_COMP:     s_nxt.rdata = {15'h0000, s_r.comp_off};
        OFF_COUNT:    s_nxt.rdata = {8'h00, s_r.count_lim};
        OFF_RTIME_LO: s_nxt.rdata = s_r.ref_time[15:0];
        OFF_RTIME_HI: s_nxt.rdata = s_r.ref_time[31:16];
        default: begin
          for (int k = 0; k < NUM_LIM; k++) begin
            if (lim_sel(ADDR, k)) begin
              s_nxt.rdata = s_r.lim[k];
            end
          end
        end
      endcase
    end

    // Alarm outputs follow the next result
    s_nxt.h_alert   = |(s_nxt.result & H_ALERT_BITS);                // [RL10] [RL6]
    s_nxt.l_alert   = |(s_nxt.result & L_ALERT_BITS);                // [RL11] [RL6]
    s_nxt.linked    = s_nxt.result[14:0] & s_nxt.mask[14:0];         // [RL12]
    s_nxt.analog    = |s_nxt.linked;                                 // [RL12]
    s_nxt.uncertain = s_nxt.mask[B_LINK_STATUS]
                    && (|s_nxt.result[14:0]);                        // [RL13]
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s_r            <= '0;
      s_r.mode       <= MODE_STOP;                                   // [RL1]
      s_r.blk_mode   <= BM_AUTO;
      s_r.period     <= PERIOD_RST;                                  // [RL4]
      s_r.pri        <= PRI_RST;                                     // [RL6]
      s_r.mask       <= MASK_RST;                                    // [RL12]
      s_r.count_lim  <= COUNT_RST;                                   // [RL18]
      s_r.result     <= RESULT_RST;                                  // [RL9]
      s_r.lim[0]     <= LIM_MAX_RST;
      s_r.lim[1]     <= LIM_MIN_RST;
      s_r.lim[2]     <= LIM_MAX_RST;
      s_r.lim[3]     <= LIM_MIN_RST;
      s_r.lim[4]     <= LIM_MAX_RST;
      s_r.lim[5]     <= LIM_MIN_RST;
      s_r.lim[6]     <= LIM_MAX_RST;
      s_r.lim[7]     <= LIM_MIN_RST;
      s_r.lim[8]     <= LIM_HI_RST;
      s_r.lim[9]     <= LIM_LO_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RDATA            = s_r.rdata;
  assign MODE_STATE       = s_r.mode;
  assign ALERT_PRIORITY   = s_r.pri;
  assign HIGH_ALERT       = s_r.h_alert;
  assign LOW_ALERT        = s_r.l_alert;
  assign LINKED_ALARMS    = s_r.linked;
  assign ANALOG_ALERT     = s_r.analog;
  assign OUTPUT_UNCERTAIN = s_r.uncertain;

endmodule : line_blockage_diag_params

`default_nettype wire

// ===== tb/lbd_host.sv
// Host model driving the register port of the diagnosis bank.
// Assumes the bank answers a read in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module lbd_host (
  // Clock
  input  wire logic                   clk,
  // Register port, master side
  output logic      [lbd_pkg::AW-1:0] addr,
  output logic      [lbd_pkg::DW-1:0] wdata,
  output logic                        wr,
  output logic                        rd,
  input  wire logic [lbd_pkg::DW-1:0] rdata
);
  import lbd_pkg::*;

  initial begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One-cycle write strobe
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // Read, data taken in the cycle after the strobe
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : lbd_host
`default_nettype wire

// ===== tb/lbd_params_assertions.sv
// Checker of the diagnosis bank outputs, bound to the top module.
// Assumes the register map and result bit positions of lbd_pkg.
`timescale 1ns/1ps
`default_nettype none
module lbd_checker #(
  parameter int CYCLES_PER_SEC = 4
) (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic [11:0] ADDR,
  input wire logic        WR,
  input wire logic [1:0]  MODE_STATE,
  input wire logic [7:0]  ALERT_PRIORITY,
  input wire logic        HIGH_ALERT,
  input wire logic        LOW_ALERT,
  input wire logic [14:0] LINKED_ALARMS,
  input wire logic        ANALOG_ALERT,
  input wire logic        OUTPUT_UNCERTAIN
);
  import lbd_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  logic [31:0] ref_cyc;

  // Cycles spent in reference mode since it was entered
  always_ff @(posedge CLK) begin
    if (!NRST || MODE_STATE != MODE_REF || (WR && ADDR == OFF_MODE)) begin
      ref_cyc <= 32'h0000_0000;
    end else begin
      ref_cyc <= ref_cyc + 32'h0000_0001;
    end
  end

  a_ref_length: assert property ($past(MODE_STATE) == MODE_REF && MODE_STATE == MODE_CALC
    && !$past(WR) |-> ref_cyc > 32'((REF_TIME_S - 1) * CYCLES_PER_SEC)
    && ref_cyc <= 32'(REF_TIME_S * CYCLES_PER_SEC))
    else $error("reference length outside its second count");

  a_mode_legal: assert property (MODE_STATE != 2'h3)
    else $error("mode left its three values");
  a_stop_quiet: assert property ($past(MODE_STATE) == MODE_STOP && MODE_STATE == MODE_STOP
    |-> !HIGH_ALERT && !LOW_ALERT && !OUTPUT_UNCERTAIN && LINKED_ALARMS == 15'h0000)
    else $error("alarm active while stopped");
  a_ref_exit: assert property ($past(MODE_STATE) == MODE_REF && MODE_STATE != MODE_REF
    |-> MODE_STATE == MODE_CALC || $past(WR) && $past(ADDR) == OFF_MODE)
    else $error("reference left to a mode other than calculation");
  a_ref_hold: assert property ($rose(MODE_STATE == MODE_REF) ##1 (!WR)[*7]
    |-> MODE_STATE == MODE_REF)
    else $error("reference ended too early");
  a_pri_locked: assert property ($changed(ALERT_PRIORITY) |-> $past(MODE_STATE) == MODE_STOP)
    else $error("priority changed outside stop");
  a_analog_link: assert property (ANALOG_ALERT == (LINKED_ALARMS != 15'h0000))
    else $error("analog alert differs from linked alarms");
  a_low_bits: assert property (LINKED_ALARMS[1:0] == 2'b00)
    else $error("result bits 0 or 1 set");
  a_high_cause: assert property ((LINKED_ALARMS & H_ALERT_BITS[14:0]) != 15'h0 |-> HIGH_ALERT)
    else $error("high alert missing");
  a_low_cause: assert property ((LINKED_ALARMS & L_ALERT_BITS[14:0]) != 15'h0 |-> LOW_ALERT)
    else $error("low alert missing");

  c_high: cover property ($rose(HIGH_ALERT));
  c_uncertain: cover property ($rose(OUTPUT_UNCERTAIN));
  c_ref_done: cover property ($past(MODE_STATE) == MODE_REF && MODE_STATE == MODE_CALC);
endmodule : lbd_checker

bind line_blockage_diag_params lbd_checker #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) i_chk (
  .CLK, .NRST, .ADDR, .WR, .MODE_STATE, .ALERT_PRIORITY, .HIGH_ALERT, .LOW_ALERT,
  .LINKED_ALARMS, .ANALOG_ALERT, .OUTPUT_UNCERTAIN);
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench of the line blockage diagnosis bank.
// Assumes the host model for register access; statistics are driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin n_compared++; if ((ac) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, ac); end end
module testbench;
  import lbd_pkg::*;
  localparam int CPS = 4;
  logic CLK, NRST, WR, RD, tlo, thi, h_al, l_al, an_al, unc;
  logic [11:0] ADDR;
  logic [15:0] WDATA, RDATA, fdp, low_side_fluct, high_side_fluct, blocking_factor, dpavg;
  logic [1:0] mode_st;
  logic [7:0] pri;
  logic [14:0] linked;
  int errors, n_compared, n;

  lbd_host i_host (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD), .rdata(RDATA));
  line_blockage_diag_params #(.CYCLES_PER_SEC(CPS)) i_dut (.CLK(CLK), .NRST(NRST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .STAT_FDP(fdp),
    .STAT_LOW_SIDE_FLUCT(low_side_fluct), .STAT_HIGH_SIDE_FLUCT(high_side_fluct), .STAT_BLOCKING_FACTOR(blocking_factor), .STAT_DPAVG(dpavg),
    .FLANGE_TEMP_LOW(tlo), .FLANGE_TEMP_HIGH(thi), .MODE_STATE(mode_st),
    .ALERT_PRIORITY(pri), .HIGH_ALERT(h_al), .LOW_ALERT(l_al), .LINKED_ALARMS(linked),
    .ANALOG_ALERT(an_al), .OUTPUT_UNCERTAIN(unc));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic rc(input string nm, input logic [11:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_host.rd_reg(a, d);
    `CHK(nm, e, d)
  endtask : rc

  // Waits for calculation mode (0), high alert up (1) or down (2)
  task automatic wait_for(input int sel, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge CLK);
      #1;
      if (sel == 0 ? mode_st === 2'h1 : h_al === (sel == 1)) return;
    end
    errors++;
    $display("CHECK FAILED wait %0d exp done got timeout", sel);
    complete_run();
  endtask : wait_for

  initial begin
    NRST = 1'b0;
    errors = 0;
    n_compared = 0;
    {fdp, low_side_fluct, high_side_fluct, blocking_factor, dpavg} = {16'h0000, 16'h0100, 16'h0100, 16'h0100, 16'h0100};
    {tlo, thi} = 2'b00;
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    rc("mode", OFF_MODE, 16'h0000);
    rc("period", OFF_PERIOD, 16'h00B4);
    rc("pri", OFF_PRI, 16'h0001);
    rc("result", OFF_RESULT, 16'h0000);
    rc("mask", OFF_MASK, 16'h08FC);
    `CHK("pri_pin", 8'h01, pri)
    $display("test reset done");
    i_host.wr_reg(OFF_MODE, 16'h0003);
    rc("mode_bad", OFF_MODE, 16'h0000);
    i_host.wr_reg(OFF_PERIOD, 16'h0013);
    rc("period_low", OFF_PERIOD, 16'h00B4);
    i_host.wr_reg(OFF_PERIOD, 16'hFFFF);
    rc("period_max", OFF_PERIOD, 16'hFFFF);
    i_host.wr_reg(OFF_PERIOD, 16'h0014);
    rc("period_min", OFF_PERIOD, 16'h0014);
    i_host.wr_reg(OFF_BLKMODE, 16'h0003);
    rc("blk_bad", OFF_BLKMODE, 16'h0002);
    i_host.wr_reg(OFF_BLKMODE, 16'h0000);
    i_host.wr_reg(OFF_COUNT, 16'h0000);
    rc("count_zero", OFF_COUNT, 16'h0003);
    i_host.wr_reg(OFF_LIM_BASE, 16'h0300);
    rc("lim_set", OFF_LIM_BASE, 16'h0300);
    i_host.wr_reg(OFF_PRI, 16'h0007);
    rc("pri_set", OFF_PRI, 16'h0007);
    rc("unmapped", 12'h000, 16'h0000);
    $display("test write ranges done");
    i_host.wr_reg(OFF_MODE, 16'h0002);
    `CHK("ref_mode", 2'h2, mode_st)
    wait_for(0, 800);
    `CHK("ref_len", 1'b1, n >= 700 && n <= 730)
    wait_for(1, 300);
    rc("inv_fdp", OFF_RESULT, 16'h0800);
    `CHK("inv_low", 1'b1, l_al)
    i_host.wr_reg(OFF_PRI, 16'h0009);
    rc("pri_lock", OFF_PRI, 16'h0007);
    i_host.wr_reg(OFF_PERIOD, 16'h0020);
    rc("period_lock", OFF_PERIOD, 16'h0014);
    i_host.wr_reg(OFF_MASK, 16'h0000);
    rc("mask_lock", OFF_MASK, 16'h08FC);
    @(posedge CLK) fdp <= 16'h0100;
    i_host.wr_reg(OFF_MODE, 16'h0002);
    wait_for(0, 800);
    wait_for(2, 200);
    rc("ref_ok", OFF_RESULT, 16'h0000);
    $display("test reference done");
    @(posedge CLK) high_side_fluct <= 16'h0001;
    wait_for(1, 300);
    `CHK("blk_count", 1'b1, n >= 155 && n <= 250)
    rc("hi_blk", OFF_RESULT, 16'h0040);
    `CHK("hi_blk_low", 1'b0, l_al)
    `CHK("linked", 15'h0040, linked)
    `CHK("analog", 1'b1, an_al)
    `CHK("unc_off", 1'b0, unc)
    @(posedge CLK) high_side_fluct <= 16'h0100;
    wait_for(2, 100);
    $display("test blockage done");
    i_host.wr_reg(OFF_MODE, 16'h0000);
    rc("stop_clr", OFF_RESULT, 16'h0000);
    i_host.wr_reg(OFF_COMP, 16'h0001);
    @(posedge CLK) dpavg <= 16'h0040;
    i_host.wr_reg(OFF_MODE, 16'h0001);
    repeat (400) @(posedge CLK);
    rc("plain", OFF_RESULT, 16'h0000);
    i_host.wr_reg(OFF_MODE, 16'h0000);
    i_host.wr_reg(OFF_COMP, 16'h0000);
    i_host.wr_reg(OFF_MODE, 16'h0001);
    wait_for(1, 400);
    rc("comp", OFF_RESULT, 16'h0004);
    `CHK("comp_low", 1'b1, l_al)
    $display("test compensation done");
    i_host.wr_reg(OFF_MODE, 16'h0000);
    i_host.wr_reg(OFF_MASK, 16'hFFFF);
    rc("mask_set", OFF_MASK, 16'hFFFF);
    @(posedge CLK) {dpavg, tlo, thi} <= {16'hFF00, 2'b11};
    i_host.wr_reg(OFF_MODE, 16'h0001);
    wait_for(1, 400);
    rc("range", OFF_RESULT, 16'h7000);
    `CHK("range_low", 1'b1, l_al)
    `CHK("linked_all", 15'h7000, linked)
    `CHK("unc_on", 1'b1, unc)
    i_host.wr_reg(OFF_MODE, 16'h0000);
    wait_for(2, 5);
    rc("stop_clr2", OFF_RESULT, 16'h0000);
    $display("test range and status done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
